// *** design/rcc_config_regs.sv ***
/*
  Channel configuration register bank of the redriver: power-down
  overrides, hot-plug polarity, per-lane equalizer, flat gain and
  swing, detector threshold and feature enables.
  Assumes a byte-level request port driven by the serial slave
  engine on the same clock, one request per cycle at most.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rcc_consts.svh"

module rcc_config_regs
  import rcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register request from the serial slave engine
  input wire rcc_req_s req,
  // Register answer
  output rcc_rsp_s rsp,
  // Hot-plug pin
  input wire logic hotplug_detect_input,
  output logic hotplug_detected,
  // Power-down overrides and hot-plug polarity
  output logic force_off_rx_lane1,
  output logic force_off_tx_lane1,
  output logic force_off_tx_lane2,
  output logic force_off_rx_lane2,
  output logic hotplug_input_polarity,
  // Lane signal settings
  output rcc_lane_cfg_s rx_lane2_cfg,
  output rcc_lane_cfg_s tx_lane2_cfg,
  output rcc_lane_cfg_s tx_lane1_cfg,
  output rcc_lane_cfg_s rx_lane1_cfg,
  // Threshold and feature enables
  output logic [1:0] signal_detect_threshold,
  output logic hotplug_pin_enable_n,
  output logic aux_listener_enable
);

  // ==========================================================
  // Functions
  function automatic rcc_lane_cfg_s unpack_lane(input rcc_byte_t b);
    rcc_lane_cfg_s c;
    c.eq = b[`RCC_EQ_HI:`RCC_EQ_LO];
    c.flat_gain = b[`RCC_FG_HI:`RCC_FG_LO];
    c.swing = b[`RCC_SW_HI:`RCC_SW_LO];
    return c;
  endfunction : unpack_lane

  function automatic logic is_lane(input rcc_byte_t a);
    return (a >= `RCC_OFS_LANE_FIRST) && (a <= `RCC_OFS_LANE_LAST);
  endfunction : is_lane

  function automatic logic lane_fields_ok(input rcc_lane_cfg_s c,
                                          input rcc_byte_t b);
    return (c.eq == b[`RCC_EQ_HI:`RCC_EQ_LO]) &&
      (c.flat_gain == b[`RCC_FG_HI:`RCC_FG_LO]) &&
      (c.swing == b[`RCC_SW_HI:`RCC_SW_LO]);
  endfunction : lane_fields_ok

  // ==========================================================
  // Storage
  // Lane bytes sit in one array, index 0 at the first lane byte.
  rcc_byte_t pd_q;
  rcc_byte_t thr_q;
  rcc_byte_t lane_q [4];
  rcc_rsp_s rsp_q;

  // ==========================================================
  // Address decode
  wire logic hit_pd = (req.addr == `RCC_OFS_PD);
  wire logic hit_thr = (req.addr == `RCC_OFS_THR);
  wire logic hit_lane = is_lane(req.addr);
  wire rcc_byte_t lane_ofs = req.addr - `RCC_OFS_LANE_FIRST;
  wire logic [1:0] lane_idx = lane_ofs[1:0];
  // Everything else, reserved bytes included, is the dummy slot.
  wire logic hit_none = !(hit_pd || hit_thr || hit_lane);

  wire logic wr_pd = req.wr && hit_pd;
  wire logic wr_thr = req.wr && hit_thr;
  wire logic wr_lane = req.wr && hit_lane;

  // ==========================================================
  // Read selection
  wire rcc_byte_t rd_sel =
    hit_pd ? pd_q :
    hit_thr ? thr_q :
    hit_lane ? lane_q[lane_idx] :
    `RCC_DUMMY_RD;

  // ==========================================================
  // Register update
  // A write lands at the edge that takes it; a read in the same
  // cycle still sees the old byte, which keeps the mux shallow.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pd_q <= `RCC_RST_PD;
      thr_q <= `RCC_RST_THR;
      for (int i = 0; i < 4; i++)
        lane_q[i] <= `RCC_RST_LANE;
    end
    else
    begin
      if (wr_pd)
        pd_q <= req.data;
      if (wr_thr)
        thr_q <= req.data;
      if (wr_lane)
        lane_q[lane_idx] <= req.data;
    end
  end

  // ==========================================================
  // Read answer
  always_ff @(posedge clock)
  begin
    if (srst)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= req.rd;
      if (req.rd)
        rsp_q.data <= rd_sel;
    end
  end

  assign rsp = rsp_q;

  // ==========================================================
  // Controls toward the analog channels
  assign force_off_rx_lane1 = pd_q[`RCC_PD_RX1];
  assign force_off_tx_lane1 = pd_q[`RCC_PD_TX1];
  assign force_off_tx_lane2 = pd_q[`RCC_PD_TX2];
  assign force_off_rx_lane2 = pd_q[`RCC_PD_RX2];
  assign hotplug_input_polarity = pd_q[`RCC_PD_POL];
  assign rx_lane2_cfg = unpack_lane(lane_q[0]);
  assign tx_lane2_cfg = unpack_lane(lane_q[1]);
  assign tx_lane1_cfg = unpack_lane(lane_q[2]);
  assign rx_lane1_cfg = unpack_lane(lane_q[3]);
  assign signal_detect_threshold =
    thr_q[`RCC_THR_HI:`RCC_THR_LO];
  assign hotplug_pin_enable_n = thr_q[`RCC_HPD_EN_N];
  assign aux_listener_enable = !thr_q[`RCC_AUX_EN_N];

  // ==========================================================
  // Hot-plug pin
  rcc_hotplug_sync u_hotplug (
    .clock(clock),
    .srst(srst),
    .hotplug_detect_input(hotplug_detect_input),
    .hotplug_input_polarity(hotplug_input_polarity),
    .hotplug_pin_enable_n(hotplug_pin_enable_n),
    .hotplug_detected(hotplug_detected)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  powerdown_write_a: assert property (
    wr_pd |=> force_off_rx_lane1 == $past(req.data[7]) &&
      force_off_tx_lane1 == $past(req.data[6]) &&
      force_off_tx_lane2 == $past(req.data[5]) &&
      force_off_rx_lane2 == $past(req.data[4]))
    else $error("power-down override not applied");

  polarity_write_a: assert property (
    wr_pd |=> hotplug_input_polarity == $past(req.data[1]))
    else $error("hot-plug polarity bit not applied");

  override_reset_a: assert property (@(posedge clock)
    disable iff (1'b0)
    srst |=> pd_q == `RCC_RST_PD && thr_q == `RCC_RST_THR)
    else $error("override or threshold reset value wrong");

  rx2_write_a: assert property (
    req.wr && req.addr == `RCC_OFS_RX2 |=> rx_lane2_cfg == $past(req.data))
    else $error("rx lane 2 settings not applied");

  tx2_write_a: assert property (
    req.wr && req.addr == `RCC_OFS_TX2 |=> tx_lane2_cfg == $past(req.data))
    else $error("tx lane 2 settings not applied");

  tx1_write_a: assert property (
    req.wr && req.addr == `RCC_OFS_TX1 |=> tx_lane1_cfg == $past(req.data))
    else $error("tx lane 1 settings not applied");

  rx1_write_a: assert property (
    req.wr && req.addr == `RCC_OFS_RX1 |=> rx_lane1_cfg == $past(req.data))
    else $error("rx lane 1 settings not applied");

  threshold_write_a: assert property (
    wr_thr |=> signal_detect_threshold == $past(req.data[7:6]))
    else $error("detector threshold not applied");

  aux_enable_a: assert property (
    wr_thr |=> aux_listener_enable == !$past(req.data[1]) &&
      hotplug_pin_enable_n == $past(req.data[2]))
    else $error("feature enables not applied");

  lane_reset_a: assert property (@(posedge clock)
    disable iff (1'b0)
    srst |=> rx_lane2_cfg == `RCC_RST_LANE &&
      tx_lane2_cfg == `RCC_RST_LANE &&
      tx_lane1_cfg == `RCC_RST_LANE &&
      rx_lane1_cfg == `RCC_RST_LANE &&
      signal_detect_threshold == `RCC_VTH_65MV)
    else $error("lane or threshold reset value wrong");

  reserved_write_a: assert property (
    req.wr && hit_none |=> $stable(pd_q) && $stable(thr_q) &&
      $stable(rx_lane2_cfg) && $stable(rx_lane1_cfg) &&
      $stable(tx_lane2_cfg) && $stable(tx_lane1_cfg))
    else $error("write to unmapped byte changed state");

  dummy_read_a: assert property (
    req.rd && hit_none |=> rsp.valid && rsp.data == `RCC_DUMMY_RD)
    else $error("unmapped read did not return FF");

  readback_a: assert property (
    (req.wr && hit_pd) ##1 (req.rd && hit_pd && !req.wr) |=>
      rsp.valid && rsp.data == $past(req.data, 2))
    else $error("read back differs from last write");

  // The answer is registered, so every read check looks one edge later.
  same_cycle_read_a: assert property (
    req.wr && req.rd && hit_thr |=>
      rsp.valid && rsp.data == $past(thr_q))
    else $error("same-cycle read did not return the old byte");

  rsp_pulse_a: assert property (
    !req.rd |=> !rsp.valid)
    else $error("read answer without a read");

  rsp_hold_a: assert property (
    !req.rd |=> $stable(rsp.data))
    else $error("read answer changed without a read");

  pd_store_a: assert property (
    wr_pd |=> pd_q == $past(req.data))
    else $error("override byte not stored as written");

  thr_store_a: assert property (
    wr_thr |=> thr_q == $past(req.data))
    else $error("threshold byte not stored as written");

  no_write_hold_a: assert property (
    !req.wr |=> $stable(pd_q) && $stable(thr_q))
    else $error("register changed without a write");

  rx2_fields_a: assert property (
    req.wr && req.addr == `RCC_OFS_RX2 |=>
      lane_fields_ok(rx_lane2_cfg, $past(req.data)))
    else $error("rx lane 2 field layout wrong");

  tx2_fields_a: assert property (
    req.wr && req.addr == `RCC_OFS_TX2 |=>
      lane_fields_ok(tx_lane2_cfg, $past(req.data)))
    else $error("tx lane 2 field layout wrong");

  tx1_fields_a: assert property (
    req.wr && req.addr == `RCC_OFS_TX1 |=>
      lane_fields_ok(tx_lane1_cfg, $past(req.data)))
    else $error("tx lane 1 field layout wrong");

  rx1_fields_a: assert property (
    req.wr && req.addr == `RCC_OFS_RX1 |=>
      lane_fields_ok(rx_lane1_cfg, $past(req.data)))
    else $error("rx lane 1 field layout wrong");

  outputs_reset_a: assert property (@(posedge clock)
    disable iff (1'b0)
    srst |=> !force_off_rx_lane1 && !force_off_tx_lane1 &&
      !force_off_tx_lane2 && !force_off_rx_lane2 &&
      !hotplug_input_polarity && !hotplug_pin_enable_n &&
      aux_listener_enable && !hotplug_detected && !rsp.valid)
    else $error("control outputs not at power-up values");

  pd_write_c: cover property (wr_pd ##1 req.rd && hit_pd);
  lane_write_c: cover property (wr_lane ##1 wr_lane);
  dummy_read_c: cover property (req.rd && hit_none);
  thr_write_c: cover property (wr_thr ##1 aux_listener_enable == 1'b0);

endmodule : rcc_config_regs

`default_nettype wire

// *** design/rcc_consts.svh ***
/*
  Offsets, reset values, field positions and codes of the redriver
  channel configuration bank.
  Assumes it is included by the bank's package users and modules.
*/
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// ==========================================================
// Register offsets
`define RCC_OFS_PD 8'h04
`define RCC_OFS_RX2 8'h05
`define RCC_OFS_TX2 8'h06
`define RCC_OFS_TX1 8'h07
`define RCC_OFS_RX1 8'h08
`define RCC_OFS_THR 8'h0c
`define RCC_OFS_LANE_FIRST 8'h05
`define RCC_OFS_LANE_LAST 8'h08

// ==========================================================
// Reset values
`define RCC_RST_PD 8'h0d
`define RCC_RST_LANE 8'h07
`define RCC_RST_THR 8'h58
`define RCC_DUMMY_RD 8'hff

// ==========================================================
// Field positions
`define RCC_PD_RX1 7
`define RCC_PD_TX1 6
`define RCC_PD_TX2 5
`define RCC_PD_RX2 4
`define RCC_PD_POL 1
`define RCC_THR_HI 7
`define RCC_THR_LO 6
`define RCC_HPD_EN_N 2
`define RCC_AUX_EN_N 1
`define RCC_EQ_HI 7
`define RCC_EQ_LO 4
`define RCC_FG_HI 3
`define RCC_FG_LO 2
`define RCC_SW_HI 1
`define RCC_SW_LO 0

// ==========================================================
// Threshold codes
`define RCC_VTH_50MV 2'h0
`define RCC_VTH_65MV 2'h1
`define RCC_VTH_80MV 2'h2
`define RCC_VTH_95MV 2'h3

`endif

// *** design/rcc_pkg.sv ***
/*
  Types shared by the redriver channel configuration bank.
  Assumes nothing of its surroundings.
*/
package rcc_pkg;

  // ==========================================================
  // Carriers
  typedef logic [7:0] rcc_byte_t;

  typedef struct packed {
    logic [3:0] eq;
    logic [1:0] flat_gain;
    logic [1:0] swing;
  } rcc_lane_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    rcc_byte_t addr;
    rcc_byte_t data;
  } rcc_req_s;

  typedef struct packed {
    logic valid;
    rcc_byte_t data;
  } rcc_rsp_s;

endpackage : rcc_pkg

// *** design/rcc_hotplug_sync.sv ***
/*
  Hot-plug-detect pin conditioning: three-stage synchroniser,
  polarity selection and pin enable.
  Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rcc_hotplug_sync
  import rcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Pin
  input wire logic hotplug_detect_input,
  // Control
  input wire logic hotplug_input_polarity,
  input wire logic hotplug_pin_enable_n,
  // Result
  output logic hotplug_detected
);

  logic [2:0] sync_q;
  logic level_q;
  logic det_q;
  wire logic agree = (sync_q[1] == sync_q[2]);
  wire logic det_d = !hotplug_pin_enable_n &&
    (level_q ^ hotplug_input_polarity);

  // ==========================================================
  // Synchroniser and filter
  // A level counts only once two late stages agree, so a glitch
  // caught by the first stage never reaches the output.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      det_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], hotplug_detect_input};
      if (agree)
        level_q <= sync_q[2];
      det_q <= det_d;
    end
  end

  assign hotplug_detected = det_q;

  // ==========================================================
  // Checks
  pin_ignored_a: assert property (@(posedge clock) disable iff (srst)
    hotplug_pin_enable_n |=> !hotplug_detected)
    else $error("hot-plug pin not ignored while disabled");

  pin_polarity_a: assert property (@(posedge clock) disable iff (srst)
    !hotplug_pin_enable_n |=>
      hotplug_detected == ($past(level_q) ^ $past(hotplug_input_polarity)))
    else $error("hot-plug polarity wrong");

  hotplug_seen_c: cover property (@(posedge clock) disable iff (srst)
    !hotplug_detected ##1 hotplug_detected);

endmodule : rcc_hotplug_sync

`default_nettype wire

// *** testbench/rcc_host_model.sv ***
/*
  Host model: drives single byte requests into the bank.
  Assumes the bank takes a request on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module rcc_host_model
  import rcc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Request and answer
  output var rcc_req_s req,
  input wire rcc_rsp_s rsp
);
  // ==========================================================
  // Bus cycles
  initial req = '0;

  // A read with no valid answer returns unknown, so it never matches.
  // The host never writes bytes 9 to 11 or 13 to 31, so it leaves them alone.
  task automatic access(input logic wr, input rcc_byte_t a,
                        input rcc_byte_t d, output rcc_byte_t q);
  begin
    @(negedge clock);
    req = '{wr: wr, rd: !wr, addr: a, data: d};
    @(negedge clock);
    q = rsp.valid ? rsp.data : 8'hxx;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  end
  endtask : access

  // Two requests on consecutive edges; q is the answer to the second.
  task automatic pair(input rcc_req_s r1, input rcc_req_s r2,
                      output rcc_byte_t q);
  begin
    @(negedge clock);
    req = r1;
    @(negedge clock);
    req = r2;
    @(negedge clock);
    q = rsp.valid ? rsp.data : 8'hxx;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~r2.addr, data: ~r2.data};
  end
  endtask : pair
endmodule : rcc_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
/*
  Self-checking bench of the configuration bank.
  Assumes the host model and the bank share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import rcc_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic pin = 1'b0;
  rcc_req_s req;
  rcc_rsp_s rsp;
  logic f_rx1, f_tx1, f_tx2, f_rx2, pol, hpd, pen_n, aux;
  logic [1:0] vth;
  rcc_lane_cfg_s cfg [4];
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  // ==========================================================
  // Design and host
  rcc_host_model host (.clock(clock), .req(req), .rsp(rsp));
  rcc_config_regs uut (.clock(clock), .srst(srst), .req(req),
    .rsp(rsp), .hotplug_detect_input(pin), .hotplug_detected(hpd),
    .force_off_rx_lane1(f_rx1), .force_off_tx_lane1(f_tx1),
    .force_off_tx_lane2(f_tx2), .force_off_rx_lane2(f_rx2),
    .hotplug_input_polarity(pol), .rx_lane2_cfg(cfg[0]),
    .tx_lane2_cfg(cfg[1]), .tx_lane1_cfg(cfg[2]),
    .rx_lane1_cfg(cfg[3]), .signal_detect_threshold(vth),
    .hotplug_pin_enable_n(pen_n), .aux_listener_enable(aux));

  initial
  begin
    forever #10 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  task automatic print_verdict;
  begin
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : print_verdict

  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic cmp8(input string what, input rcc_byte_t e,
                      input rcc_byte_t g);
  begin
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  end
  endtask : cmp8

  task automatic wr(input rcc_byte_t a, input rcc_byte_t d);
    rcc_byte_t q;
  begin
    host.access(1'b1, a, d, q);
  end
  endtask : wr

  task automatic rd(input rcc_byte_t a, input rcc_byte_t e);
    rcc_byte_t q;
  begin
    host.access(1'b0, a, 8'h00, q);
    cmp8("rsp.data", e, q);
  end
  endtask : rd

  function automatic rcc_byte_t pd_now();
    return {f_rx1, f_tx1, f_tx2, f_rx2, 2'b00, pol, 1'b0};
  endfunction : pd_now

  // ==========================================================
  // Scenarios
  task automatic t_defaults;
  begin
    rd(8'h04, 8'h0d);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(5 + i), 8'h07);
      cmp8("lane_cfg", 8'h07, cfg[i]);
    end
    rd(8'h0c, 8'h58);
    cmp8("pd_outputs", 8'h00, pd_now());
    cmp8("threshold", 8'h01, {6'h00, vth});
    cmp8("enables", 8'h01, {6'h00, pen_n, aux});
    $display("done: defaults");
  end
  endtask : t_defaults

  task automatic t_powerdown;
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, 8'h80 >> i);
      cmp8("pd_outputs", 8'h80 >> i, pd_now());
      rd(8'h04, 8'h80 >> i);
    end
    wr(8'h04, 8'h02);
    cmp8("pd_outputs", 8'h02, pd_now());
    wr(8'h04, 8'hfd);
    rd(8'h04, 8'hfd);
    $display("done: power-down overrides");
  end
  endtask : t_powerdown

  task automatic t_lanes;
    rcc_byte_t v [4];
  begin
    v = '{8'h9e, 8'h61, 8'hc8, 8'h3b};
    for (int i = 0; i < 4; i++)
      wr(8'(5 + i), v[i]);
    for (int i = 0; i < 4; i++)
    begin
      cmp8("lane_cfg", v[i], cfg[i]);
      rd(8'(5 + i), v[i]);
    end
    $display("done: lane settings");
  end
  endtask : t_lanes

  task automatic t_threshold;
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h0c, 8'(i << 6));
      cmp8("threshold", 8'(i), {6'h00, vth});
    end
    wr(8'h0c, 8'h06);
    cmp8("enables", 8'h02, {6'h00, pen_n, aux});
    rd(8'h0c, 8'h06);
    wr(8'h0c, 8'h39);
    cmp8("enables", 8'h01, {6'h00, pen_n, aux});
    rd(8'h0c, 8'h39);
    $display("done: threshold and enables");
  end
  endtask : t_threshold

  task automatic t_unmapped;
  begin
    for (int a = 0; a < 32; a++)
      if ((a < 4 || a > 8) && a != 12)
        rd(8'(a), 8'hff);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'hff);
    rd(8'h04, 8'hfd);
    rd(8'h0c, 8'h39);
    $display("done: unmapped bytes");
  end
  endtask : t_unmapped

  // The pin crosses a synchroniser of five edges; eight are allowed.
  task automatic t_hotplug;
  begin
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'h58);
    pin = 1'b1;
    repeat (2) @(negedge clock);
    cmp8("hotplug", 8'h00, {7'h00, hpd});
    repeat (8) @(negedge clock);
    cmp8("hotplug", 8'h01, {7'h00, hpd});
    wr(8'h04, 8'h02);
    repeat (8) @(negedge clock);
    cmp8("hotplug", 8'h00, {7'h00, hpd});
    pin = 1'b0;
    repeat (8) @(negedge clock);
    cmp8("hotplug", 8'h01, {7'h00, hpd});
    wr(8'h0c, 8'h5c);
    repeat (8) @(negedge clock);
    cmp8("hotplug", 8'h00, {7'h00, hpd});
    $display("done: hot-plug pin");
  end
  endtask : t_hotplug

  // Back-to-back requests: write then read, two lane writes, and a
  // write with a read of the same byte in one cycle.
  task automatic t_back_to_back;
    rcc_byte_t q;
  begin
    host.pair(rcc_req_s'{1'b1, 1'b0, 8'h04, 8'ha5},
      rcc_req_s'{1'b0, 1'b1, 8'h04, 8'h00}, q);
    cmp8("rsp.data", 8'ha5, q);
    cmp8("pd_outputs", 8'ha0, pd_now());
    host.pair(rcc_req_s'{1'b1, 1'b0, 8'h05, 8'h12},
      rcc_req_s'{1'b1, 1'b0, 8'h06, 8'h34}, q);
    cmp8("lane_cfg", 8'h12, cfg[0]);
    cmp8("lane_cfg", 8'h34, cfg[1]);
    host.pair(rcc_req_s'{1'b1, 1'b0, 8'h0c, 8'h58},
      rcc_req_s'{1'b1, 1'b1, 8'h0c, 8'h99}, q);
    cmp8("rsp.data", 8'h58, q);
    rd(8'h0c, 8'h99);
    $display("done: back-to-back requests");
  end
  endtask : t_back_to_back

  task automatic t_midreset;
  begin
    wr(8'h07, 8'hff);
    @(negedge clock);
    srst = 1'b1;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    rd(8'h07, 8'h07);
    rd(8'h04, 8'h0d);
    rd(8'h0c, 8'h58);
    cmp8("hotplug", 8'h00, {7'h00, hpd});
    $display("done: reset in mid-run");
  end
  endtask : t_midreset

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(negedge clock);
    srst = 1'b0;
    t_defaults();
    t_powerdown();
    t_lanes();
    t_threshold();
    t_unmapped();
    t_hotplug();
    t_back_to_back();
    t_midreset();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
